// *** bench/sdcos_motor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdcos_motor_model (
  input wire logic i_clock, // Clock
  input wire logic signed [31:0] i_drive, // Drive, positive is CCW
  input wire logic i_power, // Power stage on
  input wire logic i_brake, // Brake holds
  output logic o_sample, // Encoder strobe
  output logic [15:0] o_single, // Single-turn count
  output logic [15:0] o_multi // Multi-turn count
);
  logic [31:0] angle_q = 32'h0001_FFF0;
  logic [2:0] tick_q = 3'h0;
  initial o_sample = 1'b0;
  assign {o_multi, o_single} = angle_q;
  // Shaft turns only when powered and released; CCW counts up
  always @(posedge i_clock) begin
    if (i_power && !i_brake) begin
      angle_q <= angle_q + ((i_drive > 0) ? 32'h3 : (i_drive < 0) ? -32'h3 : 32'h0);
    end
    tick_q <= tick_q + 3'h1;
    o_sample <= i_power && tick_q == 3'h7;
  end
endmodule // sdcos_motor_model
`default_nettype wire

// *** bench/sdcos_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdcos_top_props (
  input wire logic i_clock, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_clock_en, // Run
  input wire logic i_od_wr, // Write strobe
  input wire logic [15:0] i_od_index, // Index
  input wire logic o_od_err, // Error
  input wire logic signed [31:0] i_cmd, // Command in
  input wire logic signed [31:0] o_motor_cmd, // Command out
  input wire logic i_batt_fault, // Battery in
  input wire logic o_batt_fault, // Battery out
  input wire logic [15:0] o_ovl_rate, // Overload rate
  input wire logic o_operation_overload_alarm, // Alarm
  input wire logic i_alarm_clr, // Alarm clear
  input wire logic i_servo_on, // Servo on
  input wire logic o_pwm_enable, // PWM
  input wire logic o_brake_engage // Brake
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  property p_ro_rate;
    i_clock_en && i_od_wr && i_od_index == 16'h2603 |=> o_od_err;
  endproperty
  a_ro_rate: assert property (p_ro_rate) else $error("rate write accepted");
  property p_cmd_sense;
    $past(i_clock_en) && !$past(i_srst) |->
      (o_motor_cmd == $past(i_cmd)) || (o_motor_cmd == -$past(i_cmd));
  endproperty
  a_cmd_sense: assert property (p_cmd_sense) else $error("motor command wrong");
  property p_batt_mask;
    o_batt_fault |-> i_batt_fault;
  endproperty
  a_batt_mask: assert property (p_batt_mask) else $error("battery fault invented");
  property p_brake_first;
    i_clock_en && $fell(i_servo_on) |-> ##[1:2] o_brake_engage;
  endproperty
  a_brake_first: assert property (p_brake_first) else $error("brake late");
  property p_pwm_hold;
    i_clock_en && $fell(i_servo_on) && o_pwm_enable |=> o_pwm_enable;
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("pwm cut at once");
  property p_pwm_brake;
    $fell(o_pwm_enable) |-> o_brake_engage;
  endproperty
  a_pwm_brake: assert property (p_pwm_brake) else $error("pwm off before brake");
  property p_alarm_set;
    i_clock_en && o_ovl_rate >= 16'd1000 |=> o_operation_overload_alarm;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm missing");
  property p_alarm_hold;
    i_clock_en && o_operation_overload_alarm && !i_alarm_clr |=> o_operation_overload_alarm;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");
  c_pwm_off: cover property ($fell(o_pwm_enable));
  c_alarm: cover property ($rose(o_operation_overload_alarm));
  c_err: cover property (o_od_err);
endmodule // sdcos_top_props
bind sdcos_top sdcos_top_props props_u (.*);
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clock = 0, i_srst = 1, i_clock_en = 1, i_od_wr = 0, i_od_rd = 0;
  logic i_alarm_clr = 0, i_servo_on = 0, i_batt_fault = 1, i_enc_valid;
  logic [15:0] i_od_index = 0, i_od_wdata = 0, i_load = 0, i_enc_single, i_enc_multi;
  logic signed [31:0] i_cmd = 0, o_motor_cmd, o_pos_actual;
  logic [14:0][15:0] i_disp_src;
  logic [15:0] o_od_rdata, o_segment_status_display, o_ovl_rate;
  logic o_od_ack, o_od_err, o_batt_fault, o_pwm_enable, o_brake_engage;
  logic o_accumulated_overload_warning, o_operation_overload_alarm;
  logic [31:0] base_pos;
  int errors = 0, comparisons = 0;
  logic [15:0] idx_t [6] = '{16'h2004, 16'h2005, 16'h2008, 16'h200F, 16'h2010, 16'h2011};
  logic [15:0] rst_t [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0032, 16'h000A};
  sdcos_top #(.P_CYCLES_PER_MS(20)) dut_u (.*);
  sdcos_motor_model motor_u (.i_clock(i_clock), .i_drive(o_motor_cmd),
    .i_power(o_pwm_enable), .i_brake(o_brake_engage), .o_sample(i_enc_valid),
    .o_single(i_enc_single), .o_multi(i_enc_multi));
  always #2.5 i_clock = ~i_clock;
  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return o_od_ack;
      1: return o_pwm_enable;
      2: return o_accumulated_overload_warning;
      default: return o_operation_overload_alarm;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic await(input int s, input logic v, input int n);
    for (int k = 0; k < n && sig(s) !== v; k++) tick(1);
    if (sig(s) !== v) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic reset_dut();
    i_srst = 1;
    tick(4);
    i_srst = 0;
  endtask
  task automatic od(input logic wr, input logic [15:0] idx, wd, exp, input logic err);
    i_od_wr = wr;
    i_od_rd = !wr;
    i_od_index = idx;
    i_od_wdata = wd;
    tick(1);
    i_od_wr = 0;
    i_od_rd = 0;
    await(0, 1, 4);
    chk(o_od_err, err);
    if (!wr && !err) chk(o_od_rdata, exp);
    tick(1);
  endtask
  task automatic pos_chk(input int m, input bit first);
    logic [31:0] e;
    for (int k = 0; k < 20 && i_enc_valid !== 1'b1; k++) tick(1);
    if (i_enc_valid !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    e = (m == 2) ? {16'h0000, i_enc_single} : {i_enc_multi, i_enc_single};
    if (m == 1) begin
      if (first) base_pos = e;
      e = base_pos - e;
    end
    tick(1);
    chk(o_pos_actual, e);
  endtask
  initial begin
    for (int c = 0; c < 15; c++) i_disp_src[c] = 16'hA000 + 16'(c);
    reset_dut();
    foreach (idx_t[i]) od(0, idx_t[i], 0, rst_t[i], 0);
    od(0, 16'h2006, 0, 0, 1);
    od(1, 16'h2603, 16'h0001, 0, 1);
    od(1, 16'h2004, 16'h0002, 0, 1);
    od(1, 16'h2005, 16'h0003, 0, 1);
    od(1, 16'h200F, 16'h0009, 0, 1);
    od(1, 16'h2010, 16'h0065, 0, 1);
    od(1, 16'h2011, 16'h03E9, 0, 1);
    od(1, 16'h2011, 16'h03E8, 0, 0);
    od(0, 16'h2011, 0, 16'h03E8, 0);
    od(1, 16'h2011, 16'h000A, 0, 0);
    $display("test registers done");
    for (int c = 0; c <= 17; c++) begin
      od(1, 16'h2008, 16'(c), 0, 0);
      tick(3);
      chk(o_segment_status_display, (c == 5 || c == 7 || c > 14) ? 16'h0 : 16'hA000 + 16'(c));
    end
    $display("test display done");
    for (int m = 0; m < 3; m++) begin
      reset_dut();
      od(1, 16'h2004, {15'h0, m == 1}, 0, 0);
      od(1, 16'h2005, 16'(m), 0, 0);
      i_cmd = 32'sd7;
      i_servo_on = 1;
      await(1, 1, 10);
      chk(o_motor_cmd, (m == 1) ? -32'sd7 : 32'sd7);
      chk(o_batt_fault, m != 2);
      pos_chk(m, 1);
      pos_chk(m, 0);
      i_servo_on = 0;
      await(1, 0, 300);
    end
    $display("test position done");
    od(1, 16'h2011, 16'h0002, 0, 0);
    i_servo_on = 1;
    await(1, 1, 10);
    i_servo_on = 0;
    tick(2);
    chk(o_brake_engage, 1);
    tick(36);
    chk(o_pwm_enable, 1);
    tick(6);
    chk(o_pwm_enable, 0);
    od(1, 16'h2011, 16'h0000, 0, 0);
    i_servo_on = 1;
    await(1, 1, 10);
    i_servo_on = 0;
    tick(3);
    chk(o_pwm_enable, 0);
    od(1, 16'h2011, 16'h0002, 0, 0);
    i_servo_on = 1;
    await(1, 1, 10);
    i_servo_on = 0;
    tick(10);
    i_servo_on = 1;
    tick(50);
    chk(o_pwm_enable, 1);
    chk(o_brake_engage, 0);
    i_servo_on = 0;
    await(1, 0, 100);
    $display("test servo off done");
    i_load = 16'd1000;
    tick(200);
    od(0, 16'h2603, 0, 16'h0000, 0);
    od(1, 16'h200F, 16'h000A, 0, 0);
    od(1, 16'h2010, 16'h000A, 0, 0);
    i_load = 16'hFFFF;
    await(2, 1, 400);
    chk(o_operation_overload_alarm, 0);
    chk(o_ovl_rate >= 16'd100, 1);
    await(3, 1, 2000);
    chk(o_accumulated_overload_warning, 0);
    i_load = 16'h0000;
    i_alarm_clr = 1;
    tick(1);
    i_alarm_clr = 0;
    chk(o_operation_overload_alarm, 1);
    tick(60);
    i_alarm_clr = 1;
    tick(1);
    i_alarm_clr = 0;
    tick(2);
    chk(o_operation_overload_alarm, 0);
    chk(o_accumulated_overload_warning, 1);
    od(1, 16'h2010, 16'h0064, 0, 0);
    tick(2);
    chk(o_accumulated_overload_warning, 0);
    $display("test overload done");
    od(1, 16'h2008, 16'h000F, 0, 0);
    tick(20000);
    chk(o_segment_status_display, 16'hFFFF);
    $display("test peak done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

// *** hw/sdcos_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdcos_params.svh"
module sdcos_delay import sdcos_pkg::*; #(
  parameter int unsigned P_CYCLES_PER_MS = `SDCOS_CYCLES_PER_MS
) (
  input wire logic i_clock, // System clock
  input wire logic i_srst, // Sync reset
  input wire logic i_clock_en, // Freeze when low
  sdcos_delay_if.timer dly // Timer control
);
  logic [31:0] pre_q;
  logic [15:0] left_q;
  logic busy_q;

  assign dly.busy = busy_q;

  // Prescaler restarts at each start, so every ms is whole
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pre_q <= 32'h00000000;
      left_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (i_clock_en) begin
      if (dly.abort) begin
        busy_q <= 1'b0;
      end else if (dly.start) begin
        pre_q <= 32'h00000000;
        left_q <= dly.len_ms;
        busy_q <= (dly.len_ms != 16'h0000);
      end else if (busy_q) begin
        if (pre_q == P_CYCLES_PER_MS - 1) begin
          pre_q <= 32'h00000000;
          left_q <= left_q - 16'h0001;
          if (left_q == 16'h0001) busy_q <= 1'b0;
        end else begin
          pre_q <= pre_q + 32'h00000001;
        end
      end
    end
  end
endmodule // sdcos_delay
`default_nettype wire

// *** hw/sdcos_top.sv ***
// What this block does
// R1: Sense 0: positive command turns CCW; sense 1: CW; feedback rises either way.
// R2: Sense setting swaps positive and negative without rewiring the motor.
// R3: Mode 0 carries multi-turn encoder value into actual position across power cycles.
// R4: Mode 1 ignores multi-turn data, actual position reads zero at power on.
// R5: Mode 2 uses single-turn only, hides battery alarms, reports single-turn position.
// R6: Display selector picks shown quantity by code 0 to 14, code 7 reserved.
// R7: Codes 15 and 16 show peak and RMS load over 15 s, 0.1% steps.
// R8: Overload accumulates only above programmed base; lower base reaches alarm sooner.
// R9: Operator should set base at or below 100% when cooling is poor.
// R10: Warning rises when accumulated rate reaches programmed level, 10 to 100%.
// R11: At 100% accumulated overload the warning becomes the overload alarm.
// R12: After servo-off PWM runs for programmed delay, 0 to 1000 ms, default 10.
// R13: Brake engages at servo-off first; PWM stops only after the delay.
// R14: Warning clears when rate drops below level, and is held off while alarm is raised.
`timescale 1ns/1ps
`default_nettype none
`include "sdcos_params.svh"
module sdcos_top import sdcos_pkg::*; #(
  parameter int unsigned P_CYCLES_PER_MS = `SDCOS_CYCLES_PER_MS
) (
  input wire logic i_clock, // System clock
  input wire logic i_srst, // Sync reset, active high
  input wire logic i_clock_en, // Freeze when low
  input wire logic i_od_wr, // Object write strobe
  input wire logic i_od_rd, // Object read strobe
  input wire logic [15:0] i_od_index, // Object index
  input wire logic [15:0] i_od_wdata, // Write value
  output logic [15:0] o_od_rdata, // Read value
  output logic o_od_ack, // Access done pulse
  output logic o_od_err, // Unknown index or bad value
  input wire logic signed [31:0] i_cmd, // Signed motion command
  output logic signed [31:0] o_motor_cmd, // Command, positive is CCW
  input wire logic i_enc_valid, // Encoder sample strobe
  input wire logic [15:0] i_enc_single, // Single-turn count
  input wire logic [15:0] i_enc_multi, // Multi-turn count
  output logic signed [31:0] o_pos_actual, // Actual position
  input wire logic i_batt_fault, // Encoder battery fault
  output logic o_batt_fault, // Battery fault after masking
  input wire logic [15:0] i_load, // Load factor, 0.1%
  input wire logic [14:0][15:0] i_disp_src, // Display sources by code
  output logic [15:0] o_segment_status_display, // Shown quantity
  output logic [15:0] o_ovl_rate, // Accumulated overload, 0.1%
  output logic o_accumulated_overload_warning, // Overload warning
  output logic o_operation_overload_alarm, // Overload alarm
  input wire logic i_alarm_clr, // Alarm reset pulse
  input wire logic i_servo_on, // Servo-on command level
  output logic o_pwm_enable, // Power stage enable
  output logic o_brake_engage // Holding brake engage
);
  sdcos_word_t sense_q, mturn_q, disp_q, base_q, warn_q, dly_q;
  logic sense_eff_q, cfg_done_q, base_set_q;
  sdcos_mt_e mt_eff_q;
  logic [31:0] pos_base_q;
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [23:0] acc_q;
  logic [15:0] peak_q, rms_q, cur_max_q;
  logic [9:0] bkt_cnt_q;
  logic [3:0] bkt_ptr_q;
  logic [35:0] cur_sq_q;
  logic [39:0] tot_sq_q;
  logic [15:0] bkt_max_q [`SDCOS_WIN_BUCKETS];
  logic [35:0] bkt_sq_q [`SDCOS_WIN_BUCKETS];
  logic servo_prev_q, pwm_q;
  logic wr_ok;
  logic [15:0] load_base;
  logic [35:0] sq_now;
  logic [15:0] peak_d, rms_d;
  logic [39:0] mean_sq;
  sdcos_delay_if dly ();

  sdcos_delay #(.P_CYCLES_PER_MS(P_CYCLES_PER_MS)) u_delay (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_clock_en(i_clock_en),
    .dly(dly)
  );

  // Write range check
  always_comb begin
    case (i_od_index)
      `SDCOS_IDX_SENSE: wr_ok = i_od_wdata <= `SDCOS_MAX_SENSE;
      `SDCOS_IDX_MTURN: wr_ok = i_od_wdata <= `SDCOS_MAX_MTURN;
      `SDCOS_IDX_DISP: wr_ok = i_od_wdata <= `SDCOS_MAX_DISP;
      `SDCOS_IDX_OVL_BASE: wr_ok = i_od_wdata >= `SDCOS_MIN_OVL_BASE &&
                                  i_od_wdata <= `SDCOS_MAX_OVL_BASE;
      `SDCOS_IDX_OVL_WARN: wr_ok = i_od_wdata >= `SDCOS_MIN_OVL_WARN &&
                                  i_od_wdata <= `SDCOS_MAX_OVL_WARN;
      `SDCOS_IDX_PWM_DLY: wr_ok = i_od_wdata <= `SDCOS_MAX_PWM_DLY;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sense_q <= `SDCOS_RST_SENSE;
      mturn_q <= `SDCOS_RST_MTURN;
      disp_q <= `SDCOS_RST_DISP;
      base_q <= `SDCOS_RST_OVL_BASE;
      warn_q <= `SDCOS_RST_OVL_WARN;
      dly_q <= `SDCOS_RST_PWM_DLY;
    end else if (i_clock_en && i_od_wr && wr_ok) begin
      case (i_od_index)
        `SDCOS_IDX_SENSE: sense_q <= i_od_wdata;
        `SDCOS_IDX_MTURN: mturn_q <= i_od_wdata;
        `SDCOS_IDX_DISP: disp_q <= i_od_wdata;
        `SDCOS_IDX_OVL_BASE: base_q <= i_od_wdata;
        `SDCOS_IDX_OVL_WARN: warn_q <= i_od_wdata;
        `SDCOS_IDX_PWM_DLY: dly_q <= i_od_wdata;
        default: sense_q <= sense_q;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_od_rdata <= 16'h0000;
      o_od_ack <= 1'b0;
      o_od_err <= 1'b0;
    end else if (i_clock_en) begin
      o_od_ack <= i_od_wr | i_od_rd;
      o_od_err <= i_od_wr ? !wr_ok : 1'b0;
      if (i_od_rd) begin
        case (i_od_index)
          `SDCOS_IDX_SENSE: o_od_rdata <= sense_q;
          `SDCOS_IDX_MTURN: o_od_rdata <= mturn_q;
          `SDCOS_IDX_DISP: o_od_rdata <= disp_q;
          `SDCOS_IDX_OVL_BASE: o_od_rdata <= base_q;
          `SDCOS_IDX_OVL_WARN: o_od_rdata <= warn_q;
          `SDCOS_IDX_PWM_DLY: o_od_rdata <= dly_q;
          `SDCOS_IDX_OVL_RATE: o_od_rdata <= o_ovl_rate;
          default: begin
            o_od_rdata <= 16'h0000;
            o_od_err <= 1'b1;
          end
        endcase
      end
    end
  end

  // Sense and encoder mode are taken after reset and while the power stage is off
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cfg_done_q <= 1'b0;
      sense_eff_q <= 1'b0;
      mt_eff_q <= SDCOS_MT_ABS;
    end else if (i_clock_en && (!cfg_done_q || (!i_servo_on && !pwm_q))) begin
      cfg_done_q <= 1'b1;
      sense_eff_q <= sense_q[0];
      mt_eff_q <= sdcos_mt_e'(mturn_q[1:0]);
    end
  end

  // Positive command maps to CCW or CW; feedback sign follows
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_motor_cmd <= 32'sh00000000;
    end else if (i_clock_en) begin
      o_motor_cmd <= sense_eff_q ? -i_cmd : i_cmd; // R1 R2
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      base_set_q <= 1'b0;
      pos_base_q <= 32'h00000000;
      o_pos_actual <= 32'sh00000000;
    end else if (i_clock_en && cfg_done_q && i_enc_valid) begin
      if (!base_set_q) begin
        base_set_q <= 1'b1;
        pos_base_q <= {i_enc_multi, i_enc_single};
      end
      case (mt_eff_q)
        SDCOS_MT_ABS: o_pos_actual <= sense_eff_q ? // R3 R1
            -$signed({i_enc_multi, i_enc_single}) : $signed({i_enc_multi, i_enc_single});
        SDCOS_MT_INCR: o_pos_actual <= !base_set_q ? 32'sh00000000 : // R4
            (sense_eff_q ? $signed(pos_base_q - {i_enc_multi, i_enc_single}) :
             $signed({i_enc_multi, i_enc_single} - pos_base_q));
        SDCOS_MT_SINGLE: o_pos_actual <= sense_eff_q ? // R5
            -$signed({16'h0000, i_enc_single}) : $signed({16'h0000, i_enc_single});
        default: o_pos_actual <= 32'sh00000000;
      endcase
    end
  end

  assign o_batt_fault = i_batt_fault && mt_eff_q != SDCOS_MT_SINGLE; // R5

  // Millisecond sampling tick for load statistics
  assign ms_tick = ms_cnt_q == P_CYCLES_PER_MS - 1;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ms_cnt_q <= 32'h00000000;
    end else if (i_clock_en) begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
    end
  end

  // Overload accumulator above base, slow decay below
  assign load_base = 16'(base_q * `SDCOS_PCT_TO_PM);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      acc_q <= 24'h000000;
    end else if (i_clock_en && ms_tick) begin
      if (i_load > load_base) begin // R8
        acc_q <= (acc_q + 24'(i_load - load_base) >= 24'(`SDCOS_OVL_FULL_PM) << `SDCOS_OVL_SHIFT)
            ? 24'(`SDCOS_OVL_FULL_PM) << `SDCOS_OVL_SHIFT : acc_q + 24'(i_load - load_base);
      end else if (acc_q >= `SDCOS_OVL_DECAY) begin
        acc_q <= acc_q - `SDCOS_OVL_DECAY;
      end
    end
  end
  assign o_ovl_rate = 16'(acc_q >> `SDCOS_OVL_SHIFT);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_operation_overload_alarm <= 1'b0;
      o_accumulated_overload_warning <= 1'b0;
    end else if (i_clock_en) begin
      if (o_ovl_rate >= `SDCOS_OVL_FULL_PM) begin
        o_operation_overload_alarm <= 1'b1; // R11
      end else if (i_alarm_clr) begin
        o_operation_overload_alarm <= 1'b0;
      end
      o_accumulated_overload_warning <= !o_operation_overload_alarm && // R10 R14
          o_ovl_rate < `SDCOS_OVL_FULL_PM &&
          o_ovl_rate >= 16'(warn_q * `SDCOS_PCT_TO_PM);
    end
  end

  // Trailing window of one-second buckets for peak and RMS
  assign sq_now = {20'h00000, i_load} * {20'h00000, i_load};
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_max_q <= 16'h0000;
      cur_sq_q <= 36'h000000000;
      bkt_cnt_q <= 10'h000;
      bkt_ptr_q <= 4'h0;
      tot_sq_q <= 40'h0000000000;
      for (int i = 0; i < `SDCOS_WIN_BUCKETS; i++) begin
        bkt_max_q[i] <= 16'h0000;
        bkt_sq_q[i] <= 36'h000000000;
      end
    end else if (i_clock_en && ms_tick) begin
      if (bkt_cnt_q == `SDCOS_BUCKET_MS) begin
        bkt_max_q[bkt_ptr_q] <= (i_load > cur_max_q) ? i_load : cur_max_q;
        bkt_sq_q[bkt_ptr_q] <= cur_sq_q + sq_now;
        tot_sq_q <= tot_sq_q - 40'(bkt_sq_q[bkt_ptr_q]) + 40'(cur_sq_q + sq_now);
        bkt_ptr_q <= (bkt_ptr_q == 4'(`SDCOS_WIN_BUCKETS - 1)) ? 4'h0 : bkt_ptr_q + 4'h1;
        bkt_cnt_q <= 10'h000;
        cur_max_q <= 16'h0000;
        cur_sq_q <= 36'h000000000;
      end else begin
        bkt_cnt_q <= bkt_cnt_q + 10'h001;
        cur_max_q <= (i_load > cur_max_q) ? i_load : cur_max_q;
        cur_sq_q <= cur_sq_q + sq_now;
      end
    end
  end

  // Peak over buckets and combinational bit-by-bit square root of the mean
  always_comb begin
    logic [31:0] rem;
    logic [15:0] root;
    rem = 32'h00000000;
    root = 16'h0000;
    peak_d = 16'h0000;
    for (int i = 0; i < `SDCOS_WIN_BUCKETS; i++) begin
      if (bkt_max_q[i] > peak_d) peak_d = bkt_max_q[i];
    end
    mean_sq = tot_sq_q / `SDCOS_WIN_SAMPLES;
    rem = mean_sq[31:0];
    for (int b = 15; b >= 0; b--) begin
      if (32'({root | (16'h0001 << b)}) * 32'({root | (16'h0001 << b)}) <= rem) begin
        root = root | (16'h0001 << b);
      end
    end
    rms_d = root;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      peak_q <= 16'h0000;
      rms_q <= 16'h0000;
      o_segment_status_display <= 16'h0000;
    end else if (i_clock_en) begin
      peak_q <= peak_d; // R7
      rms_q <= rms_d; // R7
      case (disp_q[4:0]) // R6
        `SDCOS_DISP_OVL: o_segment_status_display <= o_ovl_rate;
        `SDCOS_DISP_RSVD: o_segment_status_display <= 16'h0000;
        `SDCOS_DISP_PEAK: o_segment_status_display <= peak_q; // R7
        `SDCOS_DISP_RMS: o_segment_status_display <= rms_q; // R7
        default: o_segment_status_display <= (disp_q < 16'h000F) ?
            i_disp_src[disp_q[3:0]] : 16'h0000;
      endcase
      if (disp_q > 16'h0010) o_segment_status_display <= 16'h0000;
    end
  end

  // Servo-off: brake first, PWM held for the programmed delay
  assign dly.start = servo_prev_q && !i_servo_on; // R12
  assign dly.abort = i_servo_on;
  assign dly.len_ms = dly_q; // R12
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      servo_prev_q <= 1'b0;
      pwm_q <= 1'b0;
      o_brake_engage <= 1'b1;
    end else if (i_clock_en) begin
      servo_prev_q <= i_servo_on;
      o_brake_engage <= !i_servo_on; // R13
      if (i_servo_on) begin
        pwm_q <= 1'b1;
      end else if (!dly.busy && !dly.start) begin
        pwm_q <= 1'b0; // R12 R13
      end
    end
  end
  assign o_pwm_enable = pwm_q;
endmodule // sdcos_top
`default_nettype wire

// *** shared/sdcos_delay_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface sdcos_delay_if;
  logic start;
  logic abort;
  logic [15:0] len_ms;
  logic busy;
  modport owner (output start, output abort, output len_ms, input busy);
  modport timer (input start, input abort, input len_ms, output busy);
endinterface
`default_nettype wire

// *** shared/sdcos_params.svh ***
`ifndef SDCOS_PARAMS_SVH
`define SDCOS_PARAMS_SVH
// Object indices
`define SDCOS_IDX_SENSE 16'h2004
`define SDCOS_IDX_MTURN 16'h2005
`define SDCOS_IDX_DISP 16'h2008
`define SDCOS_IDX_OVL_BASE 16'h200F
`define SDCOS_IDX_OVL_WARN 16'h2010
`define SDCOS_IDX_PWM_DLY 16'h2011
`define SDCOS_IDX_OVL_RATE 16'h2603
// Reset values
`define SDCOS_RST_SENSE 16'h0000
`define SDCOS_RST_MTURN 16'h0000
`define SDCOS_RST_DISP 16'h0000
`define SDCOS_RST_OVL_BASE 16'h0064
`define SDCOS_RST_OVL_WARN 16'h0032
`define SDCOS_RST_PWM_DLY 16'h000A
// Legal ranges
`define SDCOS_MAX_SENSE 16'h0001
`define SDCOS_MAX_MTURN 16'h0002
`define SDCOS_MAX_DISP 16'h0064
`define SDCOS_MIN_OVL_BASE 16'h000A
`define SDCOS_MAX_OVL_BASE 16'h0078
`define SDCOS_MIN_OVL_WARN 16'h000A
`define SDCOS_MAX_OVL_WARN 16'h0064
`define SDCOS_MAX_PWM_DLY 16'h03E8
// Display codes handled inside
`define SDCOS_DISP_OVL 5'h05
`define SDCOS_DISP_RSVD 5'h07
`define SDCOS_DISP_PEAK 5'h0F
`define SDCOS_DISP_RMS 5'h10
// Timing
`define SDCOS_CLK_PERIOD_NS 5
`define SDCOS_MS_NS 1000000
`define SDCOS_CYCLES_PER_MS (`SDCOS_MS_NS / `SDCOS_CLK_PERIOD_NS)
`define SDCOS_WIN_BUCKETS 15
`define SDCOS_BUCKET_MS 10'd999
`define SDCOS_WIN_SAMPLES 40'd15000
// Overload accumulator: full scale is 1000 permille shifted up
`define SDCOS_OVL_SHIFT 12
`define SDCOS_OVL_FULL_PM 16'd1000
`define SDCOS_OVL_DECAY 24'h000001
`define SDCOS_PCT_TO_PM 16'd10
`endif

// *** shared/sdcos_pkg.sv ***
package sdcos_pkg;
  typedef logic [15:0] sdcos_word_t;
  typedef enum logic [1:0] {SDCOS_MT_ABS, SDCOS_MT_INCR, SDCOS_MT_SINGLE} sdcos_mt_e;
endpackage
